/* bench/ptc_ref_model.sv */
/*
 Far-side model: the reference oscillator and the time-standard pulse.
 Assumes the bench clock runs at the design's system rate.
*/
`timescale 1ns/1ps
`default_nettype none
module ptc_ref_model #(
   parameter int HALF = 4
) (
   input wire logic clock,
   input wire logic align_req,
   input wire logic reference_lost,
   output logic reference_in,
   output logic align_pulse_in,
   output logic msk_ok
);
   int cnt;
   initial begin
      cnt = 0;
      reference_in = 1'b0;
      align_pulse_in = 1'b0;
      msk_ok = 1'b0;
   end
   // The oscillator runs free, so it never pauses between seconds.
   always @(posedge clock) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
         reference_in <= ~reference_in;
      end
      align_pulse_in <= align_req;
      msk_ok <= ~reference_lost;
   end
endmodule
`default_nettype wire

/* bench/testbench.sv */
/*
 Self-checking bench of the time pulse clock with shortened counts.
 Assumes the reference model and the design compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int HALF = 4;
   localparam int RPS = 50;
   logic clock = 0;
   logic reset = 1;
   logic [7:0] btn = 8'h00;
   logic [2:0] pwr = 3'h1;
   logic sel = 0;
   logic align_req = 0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 0;
   logic avs_write = 0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd, v, rs;
   logic avs_waitrequest, reference_in, align_pulse_in, reference_out, second_pulse, minute_pulse;
   logic [4:0] display_hours, h;
   logic [5:0] display_minutes, display_seconds;
   logic [6:0] lamps;
   logic reference_lost, msk_ok;
   int err_total = 0;
   int n_tests = 0;
   int n, i, hits;
   ptc_ref_model #(.HALF(HALF)) partner (.clock(clock), .align_req(align_req), .reference_lost(reference_lost),
      .reference_in(reference_in), .align_pulse_in(align_pulse_in), .msk_ok(msk_ok));
   ptc_clock #(.REF_PER_SEC(RPS), .DEBOUNCE_CYCLES(4), .REPEAT_CYCLES(20)) DUT (.clock(clock), .reset(reset),
      .reference_in(reference_in), .align_pulse_in(align_pulse_in), .hour_button(btn[0]), .minute_button(btn[1]),
      .freeze_button(btn[2]), .accelerate_button(btn[3]), .minute_realign_button(btn[4]),
      .external_align_button(btn[5]), .error_clear_button(btn[6]), .indicator_check_button(btn[7]),
      .mains_present(pwr[0]), .external_battery_present(pwr[1]), .internal_battery_present(pwr[2]),
      .reference_select_switch(sel), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .reference_out(reference_out), .second_pulse(second_pulse), .minute_pulse(minute_pulse),
      .display_hours(display_hours), .display_minutes(display_minutes), .display_seconds(display_seconds),
      .minute_lamp(lamps[0]), .timing_error_lamp(lamps[1]), .mains_power_lamp(lamps[2]),
      .external_battery_lamp(lamps[3]), .internal_battery_lamp(lamps[4]), .no_backup_lamp(lamps[5]),
      .unit_selected(lamps[6]), .reference_lost(reference_lost));
   // Free-running system clock.
   initial begin
      forever #2.5 clock = ~clock;
   end
   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task automatic tally_and_finish();
      if (err_total == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
   endtask
   // Counts edges up to a second pulse; a missing pulse ends the run.
   task automatic wait_sec(output int c);
      c = 0;
      do begin
         @(posedge clock);
         c++;
      end while (second_pulse !== 1'b1 && c < 5000);
      if (c >= 5000) begin
         err_total++;
         tally_and_finish();
      end
   endtask
   // One Avalon-MM transfer; request held until waitrequest is seen low.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
      int c;
      c = 0;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clock);
         c++;
      end while (avs_waitrequest !== 1'b0 && c < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (c >= 50) begin
         err_total++;
         tally_and_finish();
      end
   endtask
   // Presses one button long enough for the filter to accept it.
   task automatic press(input int b);
      btn[b] <= 1'b1;
      tick(30);
      btn[b] <= 1'b0;
      tick(30);
   endtask
   // Main sequence.
   initial begin
      rs = 32'h1e464f8f;
      tick(6);
      reset <= 1'b0;
      tick(6);
      chk("unit_sel", 1, lamps[6]);
      // The reference copy lags the pin by two sync flops and one output flop.
      v = reference_in;
      tick(3);
      chk("ref_out", v, reference_out);
      bus(1'b0, ptc_pkg::REG_TIME, 0, rd);
      chk("time_reset", 0, rd);
      bus(1'b0, 4'hc, 0, rd);
      chk("unmapped", 0, rd);
      wait_sec(n);
      wait_sec(n);
      chk("sec_gap", RPS * 2 * HALF, n);
      tick(3);
      chk("seconds", 2, display_seconds);
      btn[ptc_pkg::BTN_ACCEL] <= 1'b1;
      wait_sec(n);
      wait_sec(n);
      wait_sec(n);
      chk("fast_gap", RPS * 2 * HALF / 5, n);
      btn[ptc_pkg::BTN_ACCEL] <= 1'b0;
      btn[ptc_pkg::BTN_FREEZE] <= 1'b1;
      tick(30);
      hits = 0;
      for (i = 0; i < 1000; i++) begin
         @(posedge clock);
         hits += (second_pulse === 1'b1 || minute_pulse === 1'b1);
      end
      chk("frozen_pulses", 0, hits);
      chk("err_set", 1, lamps[1]);
      // A 30-cycle hold while frozen steps at combo start and once more after one repeat period.
      v = display_minutes;
      press(ptc_pkg::BTN_MIN);
      chk("minutes", (v + 2) % 60, display_minutes);
      btn[ptc_pkg::BTN_FREEZE] <= 1'b0;
      tick(40);
      chk("err_held", 1, lamps[1]);
      press(ptc_pkg::BTN_CLEAR);
      chk("err_clear", 0, lamps[1]);
      h = display_hours;
      n = 1 + xs() % 3;
      repeat (n) press(ptc_pkg::BTN_HOUR);
      chk("hours", (h + n) % 24, display_hours);
      wait_sec(n);
      btn[ptc_pkg::BTN_ALIGN] <= 1'b1;
      tick(30);
      align_req <= 1'b1;
      tick(2);
      align_req <= 1'b0;
      wait_sec(n);
      chk("align_fast", 1, n < 12);
      btn[ptc_pkg::BTN_ALIGN] <= 1'b0;
      wait_sec(n);
      btn[ptc_pkg::BTN_REALIGN] <= 1'b1;
      wait_sec(n);
      chk("realign", 1, minute_pulse);
      btn[ptc_pkg::BTN_REALIGN] <= 1'b0;
      tick(2);
      chk("min_lamp", 1, lamps[0]);
      for (i = 1; i <= 60; i++) begin
         wait_sec(n);
         if (minute_pulse === 1'b1) begin
            break;
         end
      end
      chk("min_gap", 60, i);
      btn[ptc_pkg::BTN_CHECK] <= 1'b1;
      tick(30);
      chk("lamp_check", 7'h7f, lamps);
      btn[ptc_pkg::BTN_CHECK] <= 1'b0;
      tick(30);
      chk("no_backup", 1, lamps[5]);
      bus(1'b0, ptc_pkg::REG_STATUS, 0, rd);
      chk("st_mains", 1, rd[ptc_pkg::ST_MAINS]);
      pwr <= 3'h3;
      sel <= 1'b1;
      tick(10);
      chk("backup_ok", 0, lamps[5]);
      chk("unit_other", 0, lamps[6]);
      // A 3 us offset delays the next pulse by 15 reference ticks; the write itself used 3 edges.
      wait_sec(n);
      bus(1'b1, ptc_pkg::REG_OFFSET, 3, rd);
      wait_sec(n);
      chk("offset_gap", RPS * 2 * HALF + 3 * ptc_pkg::REF_PER_US * 2 * HALF - 3, n);
      chk("ref_ok", 0, reference_lost);
      chk("msk_ok", 1, msk_ok);
      repeat (3) begin
         v = xs() % 1000000;
         bus(1'b1, ptc_pkg::REG_OFFSET, v, rd);
         bus(1'b0, ptc_pkg::REG_OFFSET, 0, rd);
         chk("offset", v, rd);
      end
      bus(1'b1, ptc_pkg::REG_OFFSET, 32'h000fffff, rd);
      bus(1'b0, ptc_pkg::REG_OFFSET, 0, rd);
      chk("offset_max", 999999, rd);
      tally_and_finish();
   end
endmodule
`default_nettype wire

/* design/ptc_clock.sv */
/*
 Time pulse clock: 24-hour time of day, second and minute pulses beside
 the 5 MHz reference, panel set/freeze/accelerate controls, pulse offset,
 external alignment, timing fault flag, power lamps and lamp check.
 Assumes a 200 MHz clock, asynchronous panel and reference pins, and an
 Avalon-MM master for the registers.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Keep 24-hour hours, minutes, seconds for display.
// - Output 5 MHz reference and minute pulse.
// - Selector picks unit; only chosen unit forwarded (here it drives only the unit lamp and status bit; outputs are not gated).
// - Hour with freeze advances fast; alone steps.
// - Minute with freeze steps minutes forward.
// - Accelerate alone sets seconds.
// - Accelerate runs seconds and pulses five times faster.
// - Freeze holds time, suppresses both pulses (here an armed external align pulse still advances the seconds).
// - Realign: minute pulse next second, then sixty.
// - Pulses delayed by 0..999999 microsecond offset.
// - Align command syncs to external time pulse.
// - Minute lamp lights on each minute pulse.
// - Timing error flag set on disturbing events.
// - Clear button resets timing error flag.
// - Power lamps; no-backup only mains without batteries.
// - Indicator check forces every lamp on.
module ptc_clock #(
   parameter int REF_PER_SEC = 5_000_000,
   parameter int DEBOUNCE_CYCLES = ptc_pkg::DEBOUNCE_CYCLES,
   parameter int REPEAT_CYCLES = ptc_pkg::REPEAT_CYCLES,
   parameter bit UNIT_INDEX = 1'b0
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic reference_in,
   input wire logic align_pulse_in,
   input wire logic hour_button,
   input wire logic minute_button,
   input wire logic freeze_button,
   input wire logic accelerate_button,
   input wire logic minute_realign_button,
   input wire logic external_align_button,
   input wire logic error_clear_button,
   input wire logic indicator_check_button,
   input wire logic mains_present,
   input wire logic external_battery_present,
   input wire logic internal_battery_present,
   input wire logic reference_select_switch,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic reference_out,
   output logic second_pulse,
   output logic minute_pulse,
   output logic [4:0] display_hours,
   output logic [5:0] display_minutes,
   output logic [5:0] display_seconds,
   output logic minute_lamp,
   output logic timing_error_lamp,
   output logic mains_power_lamp,
   output logic external_battery_lamp,
   output logic internal_battery_lamp,
   output logic no_backup_lamp,
   output logic unit_selected,
   output logic reference_lost
);
   localparam int SUB_W = $clog2(REF_PER_SEC + ptc_pkg::ACCEL_FACTOR);
   localparam int SW = SUB_W + 1;
   localparam int US_W = $clog2(ptc_pkg::REF_PER_US + 1);
   localparam int RW = $clog2(REPEAT_CYCLES + 1);
   localparam int LW = $clog2(ptc_pkg::REF_LOSS_CYCLES + 1);

   function automatic logic [5:0] wrap_inc(input logic [5:0] v, input int lim);
      wrap_inc = (v == 6'(lim - 1)) ? 6'h00 : v + 6'h01;
   endfunction

   // Pin synchronisers: reference, align pulse, three power senses, selector.
   logic [5:0] pin_s1_q, pin_s2_q;
   logic [1:0] edge_q;
   logic ref_tick, align_rise;
   always_ff @(posedge clock) begin
      if (reset) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         edge_q <= '0;
      end else begin
         pin_s1_q <= {reference_select_switch, internal_battery_present, external_battery_present,
                      mains_present, align_pulse_in, reference_in};
         pin_s2_q <= pin_s1_q;
         edge_q <= pin_s2_q[1:0];
      end
   end
   assign ref_tick = pin_s2_q[0] & ~edge_q[0];
   assign align_rise = pin_s2_q[1] & ~edge_q[1];

   // Buttons are filtered before they act.
   logic [ptc_pkg::BTN_COUNT-1:0] btn_db, btn_prev_q, btn_rise;
   ptc_debounce #(.WIDTH(ptc_pkg::BTN_COUNT), .STABLE_CYCLES(DEBOUNCE_CYCLES)) u_buttons (
      .clock(clock),
      .reset(reset),
      .raw({indicator_check_button, error_clear_button, external_align_button, minute_realign_button,
            accelerate_button, freeze_button, minute_button, hour_button}),
      .clean(btn_db)
   );
   always_ff @(posedge clock) begin
      if (reset) begin
         btn_prev_q <= '0;
      end else begin
         btn_prev_q <= btn_db;
      end
   end
   assign btn_rise = btn_db & ~btn_prev_q;

   logic frozen, accel, check;
   assign frozen = btn_db[ptc_pkg::BTN_FREEZE];
   assign accel = btn_db[ptc_pkg::BTN_ACCEL];
   assign check = btn_db[ptc_pkg::BTN_CHECK];

   // Held set combinations fire at once, then again every repeat period.
   logic combo, combo_prev_q, rep_fire, hr_step, min_step;
   logic [RW-1:0] rep_q;
   assign combo = frozen & (btn_db[ptc_pkg::BTN_HOUR] | btn_db[ptc_pkg::BTN_MIN]);
   assign rep_fire = combo & (~combo_prev_q | rep_q == RW'(REPEAT_CYCLES - 1));
   assign hr_step = frozen ? (btn_db[ptc_pkg::BTN_HOUR] & rep_fire) : btn_rise[ptc_pkg::BTN_HOUR];
   assign min_step = frozen & btn_db[ptc_pkg::BTN_MIN] & rep_fire;
   always_ff @(posedge clock) begin
      if (reset) begin
         combo_prev_q <= 1'b0;
         rep_q <= '0;
      end else begin
         combo_prev_q <= combo;
         rep_q <= (!combo || rep_fire) ? '0 : rep_q + RW'(1);
      end
   end

   // Second divider: counts reference edges, five at a time while accelerating.
   logic [SUB_W-1:0] sub_q;
   logic [SW-1:0] sub_sum;
   logic sub_wrap, align_arm_q, align_hit, sec_tick;
   always_comb begin
      sub_sum = {1'b0, sub_q} + (accel ? SW'(ptc_pkg::ACCEL_FACTOR) : SW'(1));
      sub_wrap = (sub_sum >= SW'(REF_PER_SEC));
   end
   assign align_hit = align_arm_q & align_rise;
   assign sec_tick = (ref_tick & ~frozen & sub_wrap) | align_hit;
   always_ff @(posedge clock) begin
      if (reset || align_hit) begin
         sub_q <= '0;
      end else if (ref_tick && !frozen) begin
         sub_q <= sub_wrap ? SUB_W'(sub_sum - SW'(REF_PER_SEC)) : SUB_W'(sub_sum);
      end
   end

   // Align command arms; the next external pulse starts a fresh second.
   always_ff @(posedge clock) begin
      if (reset || align_hit) begin
         align_arm_q <= 1'b0;
      end else if (btn_rise[ptc_pkg::BTN_ALIGN]) begin
         align_arm_q <= 1'b1;
      end
   end

   // Time of day. A set step in the same cycle as a carry takes precedence.
   logic [4:0] hours_q;
   logic [5:0] minutes_q, seconds_q;
   always_ff @(posedge clock) begin
      if (reset) begin
         hours_q <= '0;
         minutes_q <= '0;
         seconds_q <= '0;
      end else begin
         if (sec_tick) begin
            seconds_q <= wrap_inc(seconds_q, ptc_pkg::SEC_PER_MIN);
            if (seconds_q == 6'(ptc_pkg::SEC_PER_MIN - 1)) begin
               minutes_q <= wrap_inc(minutes_q, ptc_pkg::MIN_PER_HOUR);
               if (minutes_q == 6'(ptc_pkg::MIN_PER_HOUR - 1)) begin
                  hours_q <= 5'(wrap_inc({1'b0, hours_q}, ptc_pkg::HOURS_PER_DAY));
               end
            end
         end
         if (min_step) begin
            minutes_q <= wrap_inc(minutes_q, ptc_pkg::MIN_PER_HOUR);
         end
         if (hr_step) begin
            hours_q <= 5'(wrap_inc({1'b0, hours_q}, ptc_pkg::HOURS_PER_DAY));
         end
      end
   end

   // Minute pulse counter, restarted by the realign command.
   logic [5:0] min_cnt_q;
   logic realign_arm_q, min_tick;
   assign min_tick = sec_tick & (realign_arm_q | min_cnt_q == 6'(ptc_pkg::SEC_PER_MIN - 1));
   always_ff @(posedge clock) begin
      if (reset) begin
         min_cnt_q <= '0;
         realign_arm_q <= 1'b0;
      end else begin
         if (sec_tick) begin
            min_cnt_q <= realign_arm_q ? 6'h00 : wrap_inc(min_cnt_q, ptc_pkg::SEC_PER_MIN);
            realign_arm_q <= 1'b0;
         end
         if (btn_rise[ptc_pkg::BTN_REALIGN]) begin
            realign_arm_q <= 1'b1;
         end
      end
   end

   // Offset delay in microsecond steps of real reference time, even when accelerated.
   // A new boundary before a pending pulse has fired restarts the delay.
   logic [19:0] offset_q, dly_q;
   logic [US_W-1:0] us_q;
   logic pend_sec_q, pend_min_q, us_wrap, fire_now, delay_done, fire_sec, fire_min;
   assign us_wrap = ref_tick & (us_q == US_W'(ptc_pkg::REF_PER_US - 1));
   assign fire_now = sec_tick & (offset_q == '0);
   assign delay_done = pend_sec_q & us_wrap & (dly_q == 20'h00001);
   assign fire_sec = fire_now | delay_done;
   assign fire_min = (fire_now & min_tick) | (delay_done & pend_min_q);
   always_ff @(posedge clock) begin
      if (reset) begin
         dly_q <= '0;
         us_q <= '0;
         pend_sec_q <= 1'b0;
         pend_min_q <= 1'b0;
      end else if (sec_tick && offset_q != '0) begin
         dly_q <= offset_q;
         us_q <= '0;
         pend_sec_q <= 1'b1;
         pend_min_q <= min_tick;
      end else begin
         if (ref_tick) begin
            us_q <= us_wrap ? '0 : us_q + US_W'(1);
         end
         if (us_wrap && pend_sec_q) begin
            dly_q <= dly_q - 20'h00001;
         end
         if (delay_done) begin
            pend_sec_q <= 1'b0;
            pend_min_q <= 1'b0;
         end
      end
   end

   // Pulse outputs are gated by freeze at the last stage.
   logic second_pulse_q, minute_pulse_q, ref_out_q, lamp_hold_q;
   always_ff @(posedge clock) begin
      if (reset) begin
         second_pulse_q <= 1'b0;
         minute_pulse_q <= 1'b0;
         ref_out_q <= 1'b0;
         lamp_hold_q <= 1'b0;
      end else begin
         second_pulse_q <= fire_sec & ~frozen;
         minute_pulse_q <= fire_min & ~frozen;
         ref_out_q <= pin_s2_q[0];
         if (fire_min && !frozen) begin
            lamp_hold_q <= 1'b1;
         end else if (fire_sec && !frozen) begin
            lamp_hold_q <= 1'b0;
         end
      end
   end

   // Reference watchdog; terminals must leave MSK while this is high.
   logic [LW-1:0] loss_q;
   logic ref_lost_q, lost_prev_q, mains_prev_q, err_event, err_q;
   always_ff @(posedge clock) begin
      if (reset || ref_tick) begin
         loss_q <= '0;
      end else if (loss_q != LW'(ptc_pkg::REF_LOSS_CYCLES)) begin
         loss_q <= loss_q + LW'(1);
      end
   end

   // Timing fault: reference loss, freeze, or loss of mains. Set wins over clear.
   assign err_event = (ref_lost_q & ~lost_prev_q) | btn_rise[ptc_pkg::BTN_FREEZE] | (mains_prev_q & ~pin_s2_q[2]);
   always_ff @(posedge clock) begin
      if (reset) begin
         ref_lost_q <= 1'b0;
         lost_prev_q <= 1'b0;
         mains_prev_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         ref_lost_q <= (loss_q == LW'(ptc_pkg::REF_LOSS_CYCLES));
         lost_prev_q <= ref_lost_q;
         mains_prev_q <= pin_s2_q[2];
         if (err_event) begin
            err_q <= 1'b1;
         end else if (btn_db[ptc_pkg::BTN_CLEAR]) begin
            err_q <= 1'b0;
         end
      end
   end

   // Panel lamps; the check button overrides every one.
   logic [6:0] lamps_q;
   logic unit_sel_q;
   always_ff @(posedge clock) begin
      if (reset) begin
         lamps_q <= '0;
         unit_sel_q <= 1'b0;
      end else begin
         unit_sel_q <= (pin_s2_q[5] == UNIT_INDEX);
         lamps_q[0] <= check | lamp_hold_q;
         lamps_q[1] <= check | err_q;
         lamps_q[2] <= check | pin_s2_q[2];
         lamps_q[3] <= check | (~pin_s2_q[2] & pin_s2_q[3]);
         lamps_q[4] <= check | (~pin_s2_q[2] & ~pin_s2_q[3] & pin_s2_q[4]);
         lamps_q[5] <= check | (pin_s2_q[2] & ~pin_s2_q[3] & ~pin_s2_q[4]);
         lamps_q[6] <= check | unit_sel_q;
      end
   end

   // Avalon slave: one wait cycle, then the answer; writes land on the next edge, the one that ends the answer cycle.
   logic wait_q;
   logic [31:0] rdata_q, rd_d;
   always_comb begin
      rd_d = 32'h00000000;
      unique case (avs_address)
         ptc_pkg::REG_OFFSET: rd_d[19:0] = offset_q;
         ptc_pkg::REG_TIME: begin
            rd_d[ptc_pkg::TIME_HOUR_LSB +: 5] = hours_q;
            rd_d[ptc_pkg::TIME_MIN_LSB +: 6] = minutes_q;
            rd_d[ptc_pkg::TIME_SEC_LSB +: 6] = seconds_q;
         end
         ptc_pkg::REG_STATUS: begin
            rd_d[ptc_pkg::ST_ERROR] = err_q;
            rd_d[ptc_pkg::ST_REF_LOST] = ref_lost_q;
            rd_d[ptc_pkg::ST_SELECTED] = unit_sel_q;
            rd_d[ptc_pkg::ST_MAINS] = pin_s2_q[2];
            rd_d[ptc_pkg::ST_EXT_BATT] = pin_s2_q[3];
            rd_d[ptc_pkg::ST_INT_BATT] = pin_s2_q[4];
            rd_d[ptc_pkg::ST_FROZEN] = frozen;
         end
         default: rd_d = 32'h00000000;
      endcase
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         wait_q <= 1'b1;
         rdata_q <= '0;
         offset_q <= ptc_pkg::OFFSET_RESET;
      end else begin
         if ((avs_read || avs_write) && wait_q) begin
            wait_q <= 1'b0;
            rdata_q <= avs_read ? rd_d : 32'h00000000;
         end else begin
            wait_q <= 1'b1;
         end
         if (avs_write && !wait_q && avs_address == ptc_pkg::REG_OFFSET) begin
            offset_q <= (avs_writedata > 32'(ptc_pkg::OFFSET_MAX_US)) ? 20'(ptc_pkg::OFFSET_MAX_US)
                        : avs_writedata[19:0];
         end
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign reference_out = ref_out_q;
   assign second_pulse = second_pulse_q;
   assign minute_pulse = minute_pulse_q;
   assign display_hours = hours_q;
   assign display_minutes = minutes_q;
   assign display_seconds = seconds_q;
   assign minute_lamp = lamps_q[0];
   assign timing_error_lamp = lamps_q[1];
   assign mains_power_lamp = lamps_q[2];
   assign external_battery_lamp = lamps_q[3];
   assign internal_battery_lamp = lamps_q[4];
   assign no_backup_lamp = lamps_q[5];
   assign unit_selected = lamps_q[6];
   assign reference_lost = ref_lost_q;

   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   time_range_a: assert property (hours_q < 5'd24 && minutes_q < 6'd60 && seconds_q < 6'd60)
      else $error("time of day out of range");
   accel_step_a: assert property (ref_tick && accel && !frozen && !align_hit && !sub_wrap
      |=> sub_q == $past(sub_q) + SUB_W'(5)) else $error("accelerated divider did not step by five");
   freeze_quiet_a: assert property (frozen |=> !second_pulse && !minute_pulse)
      else $error("pulse emitted while frozen");
   realign_cnt_a: assert property (realign_arm_q && sec_tick |=> min_cnt_q == 6'h00)
      else $error("realign did not restart minute count");
   zero_offset_a: assert property (sec_tick && offset_q == '0 && !frozen |=> second_pulse)
      else $error("second pulse missing with zero offset");
   minute_lamp_a: assert property (minute_pulse |=> minute_lamp)
      else $error("minute lamp not lit after minute pulse");
   error_clear_a: assert property (btn_db[ptc_pkg::BTN_CLEAR] && !err_event ##1 !check |=> !timing_error_lamp)
      else $error("error flag not cleared");
   error_hold_a: assert property (err_q && !btn_db[ptc_pkg::BTN_CLEAR] |=> err_q)
      else $error("error flag dropped without clear");
   lamp_check_a: assert property (check |=> (&lamps_q))
      else $error("indicator check did not light all lamps");
   no_backup_a: assert property (!check |=> no_backup_lamp == ($past(pin_s2_q[2]) && !$past(pin_s2_q[3])
      && !$past(pin_s2_q[4])))
      else $error("no-backup lamp wrong");
endmodule
`default_nettype wire

/* design/ptc_debounce.sv */
/*
 Button filter: two-flop synchroniser per bit, then a bit follows its
 input only after two equal samples taken a full sample period apart.
 Assumes raw inputs are asynchronous pins of any bounce.
*/
`timescale 1ns/1ps
`default_nettype none
module ptc_debounce #(
   parameter int WIDTH = 8,
   parameter int STABLE_CYCLES = ptc_pkg::DEBOUNCE_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] clean
);
   localparam int CW = $clog2(STABLE_CYCLES + 1);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] sample_q;
   logic [WIDTH-1:0] clean_q;
   logic [CW-1:0] cnt_q;
   logic tick;

   assign tick = (cnt_q == CW'(STABLE_CYCLES - 1));
   assign clean = clean_q;

   // Synchroniser; the first stage feeds only the second.
   always_ff @(posedge clock) begin
      if (reset) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end

   // Sample period counter shared by all bits, which saves area.
   always_ff @(posedge clock) begin
      if (reset || tick) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   // A bit changes only when two samples agree, so bounce shorter than a period is lost.
   always_ff @(posedge clock) begin
      if (reset) begin
         sample_q <= '0;
         clean_q <= '0;
      end else if (tick) begin
         sample_q <= s2_q;
         clean_q <= (~(s2_q ^ sample_q) & s2_q) | ((s2_q ^ sample_q) & clean_q);
      end
   end
endmodule
`default_nettype wire

/* design/ptc_pkg.sv */
/*
 Shared constants of the time pulse clock: clock rates, timing counts,
 register map, field positions and panel button indexes.
 Assumes a 200 MHz system clock and a 5 MHz reference applied on a pin.
*/
package ptc_pkg;
   // Rates.
   localparam int CLK_HZ = 200_000_000;
   localparam int REF_HZ = 5_000_000;
   localparam int US_PER_S = 1_000_000;
   localparam int REF_PER_US = REF_HZ / US_PER_S;
   localparam int ACCEL_FACTOR = 5;
   // Time-of-day limits.
   localparam int SEC_PER_MIN = 60;
   localparam int MIN_PER_HOUR = 60;
   localparam int HOURS_PER_DAY = 24;
   // Pulse offset range in microseconds.
   localparam int OFFSET_MAX_US = 999_999;
   localparam int OFFSET_W = 20;
   localparam logic [19:0] OFFSET_RESET = 20'h00000;
   // Button filter and held-combination repeat times.
   localparam int DEBOUNCE_MS = 5;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int REPEAT_MS = 200;
   localparam int REPEAT_CYCLES = REPEAT_MS * (CLK_HZ / 1000);
   // Reference considered lost after this long with no edge (rounded down).
   localparam int REF_LOSS_NS = 1000;
   localparam int REF_LOSS_CYCLES = REF_LOSS_NS * (CLK_HZ / US_PER_S) / 1000;
   // Register byte addresses.
   localparam int ADDR_W = 4;
   localparam logic [3:0] REG_OFFSET = 4'h0;
   localparam logic [3:0] REG_TIME = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   // Time register fields.
   localparam int TIME_HOUR_LSB = 16;
   localparam int TIME_MIN_LSB = 8;
   localparam int TIME_SEC_LSB = 0;
   // Status register bits.
   localparam int ST_ERROR = 0;
   localparam int ST_REF_LOST = 1;
   localparam int ST_SELECTED = 2;
   localparam int ST_MAINS = 3;
   localparam int ST_EXT_BATT = 4;
   localparam int ST_INT_BATT = 5;
   localparam int ST_FROZEN = 6;
   // Panel button indexes.
   localparam int BTN_HOUR = 0;
   localparam int BTN_MIN = 1;
   localparam int BTN_FREEZE = 2;
   localparam int BTN_ACCEL = 3;
   localparam int BTN_REALIGN = 4;
   localparam int BTN_ALIGN = 5;
   localparam int BTN_CLEAR = 6;
   localparam int BTN_CHECK = 7;
   localparam int BTN_COUNT = 8;
endpackage
